// *** core/fully_closed_loop_feedback.sv ***
// Fully-closed loop feedback: divided pulse output, overspeed and error alarms,
// deviation carry-over, monitor select and speed source. Settings are plain ports.
`timescale 1ns/10ps

// Summary of operation
// - Output edges per scale pitch 1..4096, default 20, latched at restart.
// - Overspeed alarm when requested edge rate exceeds 6.4 Mpps.
// - Resolution capped at 4096 edges per pitch.
// - Alarm when motor-load difference exceeds threshold, default 1000.
// - Threshold zero disables the motor-load overflow alarm.
// - Each new rotation carries deviation times one minus multiplier percent.
// - Multiplier zero uses external position unmodified.
// - Monitor code 07 routes deviation at 0.01 V per unit, immediately.
// - Speed source 0 motor, 1 external, latched at restart.
// - External speed ignored when external encoder unused.
// - Phase B leads A for forward, regardless of direction selection.
// - Forward counts up, reverse counts down.
module fully_closed_loop_feedback (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        scale_step,
  input  wire logic        scale_step_up,
  input  wire logic        scale_index,
  input  wire logic [12:0] divided_output_resolution,
  input  wire logic [1:0]  external_encoder_usage,
  input  wire logic [1:0]  speed_feedback_source_select,
  input  wire logic        rotation_direction_select,
  input  wire logic [31:0] motor_position,
  input  wire logic [31:0] load_position,
  input  wire logic        rotation_start,
  input  wire logic [30:0] motor_load_error_threshold,
  input  wire logic [6:0]  per_rotation_deviation_multiplier,
  input  wire logic [7:0]  analog_monitor_one_select,
  input  wire logic [7:0]  analog_monitor_two_select,
  input  wire logic [31:0] motor_speed,
  input  wire logic [31:0] external_speed,
  output logic             divided_phase_a_out,
  output logic             divided_phase_b_out,
  output logic             divided_index_out,
  output logic             divided_output_overspeed_alarm,
  output logic             motor_load_error_overflow_alarm,
  output logic [31:0]      corrected_load_position,
  output logic [31:0]      motor_load_deviation,
  output logic [31:0]      analog_monitor_one,
  output logic [31:0]      analog_monitor_two,
  output logic [31:0]      speed_feedback,
  output logic             speed_from_external
);
  // --------------------------------
  // Functions
  // --------------------------------
  function automatic logic [31:0] monitor_value(input logic [7:0] sel, input logic [31:0] dev);
    monitor_value = (sel == fcl_pkg::MON_SEL_DEVIATION) ? dev : 32'h0000_0000;
  endfunction : monitor_value

  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? (32'h0000_0000 - v) : v;
  endfunction : abs32

  // --------------------------------
  // Settings latched at restart
  // --------------------------------
  logic [12:0] resolution;
  logic        speed_ext_sel;
  logic        restart_done;

  always_ff @(posedge clock) begin
    if (rst) begin
      resolution    <= fcl_pkg::RES_DEFAULT;
      speed_ext_sel <= 1'b0;
      restart_done  <= 1'b0;
    end else if (!restart_done) begin
      restart_done <= 1'b1;
      if (divided_output_resolution > fcl_pkg::RES_MAX) begin
        resolution <= fcl_pkg::RES_MAX;
      end else if (divided_output_resolution < fcl_pkg::RES_MIN) begin
        resolution <= fcl_pkg::RES_MIN;
      end else begin
        resolution <= divided_output_resolution;
      end
      speed_ext_sel <= (speed_feedback_source_select == fcl_pkg::SPD_SRC_EXT) &&
                       (external_encoder_usage != fcl_pkg::EXT_ENC_NOT_USED);
    end
  end

  // --------------------------------
  // Divided pulse scaling
  // --------------------------------
  // Each scale step adds resolution to an accumulator of 4096 per edge
  logic [13:0] accum;
  logic        accum_up;
  logic [15:0] backlog;
  logic [4:0]  spacing;
  logic        emit;
  logic [13:0] next_accum;
  logic [1:0]  new_edges;

  // Direction of counting follows the scale, independent of motor direction
  always_comb begin
    next_accum = accum;
    new_edges  = 2'd0;
    if (scale_step) begin
      next_accum = accum + {1'b0, resolution};
      if (next_accum >= {1'b0, fcl_pkg::RES_MAX}) begin
        next_accum = next_accum - {1'b0, fcl_pkg::RES_MAX};
        new_edges  = 2'd1;
      end
    end
  end

  assign emit = (backlog != 16'h0000) && (spacing == 5'h00);

  always_ff @(posedge clock) begin
    if (rst) begin
      accum <= 14'h0000;
    end else begin
      accum <= next_accum;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      accum_up <= 1'b1;
      backlog  <= 16'h0000;
    end else if (new_edges != 2'd0 && scale_step_up != accum_up && backlog > {15'h0000, emit}) begin
      backlog <= backlog - (emit ? 16'h0002 : 16'h0001);
    end else if (new_edges != 2'd0) begin
      accum_up <= scale_step_up;
      if (backlog != 16'hFFFF) begin
        backlog <= backlog + 16'h0001 - {15'h0000, emit};
      end
    end else if (emit) begin
      backlog <= backlog - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      spacing <= 5'h00;
    end else if (emit) begin
      spacing <= fcl_pkg::EDGE_SPACING - 5'h01;
    end else if (spacing != 5'h00) begin
      spacing <= spacing - 5'h01;
    end
  end

  // Edges pile up only when the request exceeds the rate limit
  always_ff @(posedge clock) begin
    if (rst) begin
      divided_output_overspeed_alarm <= 1'b0;
    end else if (backlog > 16'h0001) begin
      divided_output_overspeed_alarm <= 1'b1;
    end
  end

  quad_pulse_gen u_quad (
    .clock   (clock),
    .rst     (rst),
    .step    (emit),
    .step_up (accum_up),
    .phase_a (divided_phase_a_out),
    .phase_b (divided_phase_b_out)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      divided_index_out <= 1'b0;
    end else begin
      divided_index_out <= scale_index;
    end
  end

  // --------------------------------
  // Deviation and alarms
  // --------------------------------
  logic [31:0] carry_dev;
  logic [31:0] raw_dev;
  logic [31:0] live_dev;
  logic [38:0] scaled;

  assign raw_dev  = motor_position - load_position;
  assign live_dev = raw_dev - carry_dev;
  // Share of the live deviation removed at each rotation start
  assign scaled   = $signed(live_dev) * $signed({1'b0, per_rotation_deviation_multiplier});

  always_ff @(posedge clock) begin
    if (rst) begin
      carry_dev <= 32'h0000_0000;
    end else if (per_rotation_deviation_multiplier == 7'h00) begin
      carry_dev <= 32'h0000_0000;
    end else if (rotation_start) begin
      carry_dev <= carry_dev + 32'($signed(scaled) / $signed(39'h0064));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      corrected_load_position <= 32'h0000_0000;
      motor_load_deviation    <= 32'h0000_0000;
    end else begin
      corrected_load_position <= load_position + carry_dev;
      motor_load_deviation    <= live_dev;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      motor_load_error_overflow_alarm <= 1'b0;
    end else if (motor_load_error_threshold != 31'h0000_0000 &&
                 abs32(motor_load_deviation) > {1'b0, motor_load_error_threshold}) begin
      motor_load_error_overflow_alarm <= 1'b1;
    end
  end

  // --------------------------------
  // Monitor and speed feedback
  // --------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      analog_monitor_one <= 32'h0000_0000;
      analog_monitor_two <= 32'h0000_0000;
      speed_feedback     <= 32'h0000_0000;
    end else begin
      analog_monitor_one <= monitor_value(analog_monitor_one_select, motor_load_deviation);
      analog_monitor_two <= monitor_value(analog_monitor_two_select, motor_load_deviation);
      speed_feedback     <= speed_ext_sel ? external_speed : motor_speed;
    end
  end

  assign speed_from_external = speed_ext_sel;
endmodule : fully_closed_loop_feedback

// *** core/fcl_pkg.sv ***
// Package of constants for the fully-closed loop feedback logic.
// Assumes a 125 MHz clock; shared by the top module, the checker and the testbench.
package fcl_pkg;
  localparam int unsigned CLOCK_HZ            = 125000000;
  localparam int unsigned RES_WIDTH           = 13;
  localparam logic [12:0] RES_MIN             = 13'h0001;
  localparam logic [12:0] RES_MAX             = 13'h1000;
  localparam logic [12:0] RES_DEFAULT         = 13'h0014;
  localparam int unsigned EDGE_RATE_LIMIT_PPS = 6400000;
  // Least spacing of output edges in clock cycles, rounded up
  localparam int unsigned EDGE_SPACING_CYCLES =
    (CLOCK_HZ + EDGE_RATE_LIMIT_PPS - 1) / EDGE_RATE_LIMIT_PPS;
  localparam logic [4:0]  EDGE_SPACING        = 5'(EDGE_SPACING_CYCLES);
  localparam logic [30:0] ERR_THRESH_MAX      = 31'h4000_0000;
  localparam logic [30:0] ERR_THRESH_DEFAULT  = 31'h0000_03E8;
  localparam logic [6:0]  MULT_MAX            = 7'h64;
  localparam logic [6:0]  MULT_DEFAULT        = 7'h14;
  localparam logic [7:0]  MON_SEL_DEVIATION   = 8'h07;
  localparam logic [1:0]  EXT_ENC_NOT_USED    = 2'h0;
  localparam logic [1:0]  SPD_SRC_MOTOR       = 2'h0;
  localparam logic [1:0]  SPD_SRC_EXT         = 2'h1;
  // Analog monitor code per reference unit: 0.01 V per unit, 1 LSB = 0.01 V
  localparam int unsigned MON_LSB_PER_UNIT    = 1;
  localparam int unsigned BACKLOG_WIDTH       = 16;
endpackage : fcl_pkg

// *** core/quad_pulse_gen.sv ***
// Quadrature pulse generator for the divided outputs.
// Assumes requests arrive one step at a time; spacing is enforced by the caller.
`timescale 1ns/10ps
module quad_pulse_gen (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic step,
  input  wire logic step_up,
  output logic      phase_a,
  output logic      phase_b
);
  // --------------------------------
  // Gray-coded quadrature position
  // --------------------------------
  typedef enum logic [1:0] {
    Q0 = 2'b00,
    Q1 = 2'b01,
    Q2 = 2'b11,
    Q3 = 2'b10
  } quad_t;

  quad_t state;

  // Up direction: B leads A (B rises first)
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= Q0;
    end else if (step) begin
      unique case (state)
        Q0: state <= step_up ? Q1 : Q3;
        Q1: state <= step_up ? Q2 : Q0;
        Q2: state <= step_up ? Q3 : Q1;
        Q3: state <= step_up ? Q0 : Q2;
      endcase
    end
  end

  // Phases straight from the state flops: A is bit 1, B is bit 0
  assign phase_a = state[1];
  assign phase_b = state[0];
endmodule : quad_pulse_gen

// *** testbench/fcl_chk.sv ***
// Checker on the ports of the fully-closed loop feedback top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module fcl_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        scale_step_up,
  input wire logic        scale_index,
  input wire logic [30:0] motor_load_error_threshold,
  input wire logic [7:0]  analog_monitor_one_select,
  input wire logic        divided_phase_a_out,
  input wire logic        divided_phase_b_out,
  input wire logic        divided_index_out,
  input wire logic        divided_output_overspeed_alarm,
  input wire logic        motor_load_error_overflow_alarm,
  input wire logic [31:0] motor_load_deviation,
  input wire logic [31:0] analog_monitor_one
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [4:0]  quiet;
  logic [31:0] abs_dev;
  logic [31:0] thr;
  assign abs_dev = motor_load_deviation[31] ? -motor_load_deviation : motor_load_deviation;
  assign thr     = {1'b0, motor_load_error_threshold};
  // Cycles since the last phase change
  always_ff @(posedge clock) begin
    if (rst)
      quiet <= 5'h1F;
    else if ($changed(divided_phase_a_out) || $changed(divided_phase_b_out))
      quiet <= 5'h00;
    else if (quiet != 5'h1F)
      quiet <= quiet + 5'h01;
  end
  AST_INDEX: assert property (!$past(rst) |-> divided_index_out == $past(scale_index))
    else $error("index output does not follow scale index");
  AST_QUAD: assert property (!($changed(divided_phase_a_out) && $changed(divided_phase_b_out)))
    else $error("both phases changed together");
  AST_SPACING: assert property (($changed(divided_phase_a_out) || $changed(divided_phase_b_out))
    |-> quiet >= fcl_pkg::EDGE_SPACING - 5'h01) else $error("output edges too close");
  AST_FWD: assert property ($rose(divided_phase_b_out) && scale_step_up |-> !divided_phase_a_out)
    else $error("phase b does not lead when counting up");
  AST_REV: assert property ($rose(divided_phase_b_out) && !scale_step_up |-> divided_phase_a_out)
    else $error("phase a does not lead when counting down");
  AST_OVERFLOW: assert property ($rose(motor_load_error_overflow_alarm)
    |-> $past(thr) != 0 && $past(abs_dev) > $past(thr)) else $error("overflow alarm without cause");
  AST_NO_OVERFLOW: assert property (!motor_load_error_overflow_alarm && abs_dev <= thr
    |=> !motor_load_error_overflow_alarm) else $error("overflow alarm within threshold");
  AST_MON: assert property (!$past(rst) && $past(analog_monitor_one_select) != fcl_pkg::MON_SEL_DEVIATION
    |-> analog_monitor_one == 32'h0000_0000) else $error("monitor not zero when unselected");
  cover property ($rose(divided_output_overspeed_alarm));
  cover property ($rose(motor_load_error_overflow_alarm));
  cover property ($rose(divided_phase_b_out) && !scale_step_up);
endmodule : fcl_chk
bind fully_closed_loop_feedback fcl_chk i_chk (.*);

// *** testbench/scale_encoder_model.sv ***
// Model of the external scale: count pulses, direction and index mark.
// Drives on the falling edge of the shared clock.
`timescale 1ns/10ps
module scale_encoder_model (
  input  wire logic clock,
  output logic      scale_step,
  output logic      scale_step_up,
  output logic      scale_index
);
  initial begin
    scale_step    = 1'b0;
    scale_step_up = 1'b1;
    scale_index   = 1'b0;
  end
  // Gap zero gives back-to-back counts
  task automatic send(input int n, input int gap, input logic up);
    @(negedge clock);
    scale_step_up = up;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      scale_step = 1'b1;
      if (gap > 0) begin
        @(negedge clock);
        scale_step = 1'b0;
        repeat (gap - 1) @(negedge clock);
      end
    end
    @(negedge clock);
    scale_step  = 1'b0;
    scale_index = 1'b1;
    @(negedge clock);
    scale_index = 1'b0;
  endtask : send
endmodule : scale_encoder_model

// *** testbench/test_fully_closed_loop_feedback.sv ***
// Self-checking bench for the fully-closed loop feedback block.
// Assumes the scale model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module test_fully_closed_loop_feedback;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        scale_step, scale_step_up, scale_index, rotation_direction_select, rotation_start;
  logic [12:0] divided_output_resolution;
  logic [1:0]  external_encoder_usage, speed_feedback_source_select;
  logic [31:0] motor_position, load_position, motor_speed, external_speed;
  logic [30:0] motor_load_error_threshold;
  logic [6:0]  per_rotation_deviation_multiplier;
  logic [7:0]  analog_monitor_one_select, analog_monitor_two_select;
  logic        divided_phase_a_out, divided_phase_b_out, divided_index_out;
  logic        divided_output_overspeed_alarm, motor_load_error_overflow_alarm, speed_from_external;
  logic [31:0] corrected_load_position, motor_load_deviation, analog_monitor_one, analog_monitor_two;
  logic [31:0] speed_feedback;
  int          n_errors = 0, n_compared = 0, n_edges = 0, cycles = 0;
  always #4 clock = ~clock;
  fully_closed_loop_feedback i_dut (.*);
  scale_encoder_model i_enc (.*);
  always @(posedge clock) begin
    if ($changed(divided_phase_a_out) || $changed(divided_phase_b_out))
      n_edges++;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic restart(input logic [12:0] res, input logic [1:0] use_ext, input logic [1:0] src);
    @(negedge clock);
    rst = 1'b1;
    divided_output_resolution    = res;
    external_encoder_usage       = use_ext;
    speed_feedback_source_select = src;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    n_edges = 0;
  endtask : restart
  task automatic t_pulses;
    restart(fcl_pkg::RES_MAX, 2'h1, fcl_pkg::SPD_SRC_EXT);
    rotation_direction_select = 1'b1;
    i_enc.send(3, 25, 1'b1);
    repeat (30) @(negedge clock);
    chk("edges up", 32'd3, 32'(n_edges));
    chk("phases up", 32'h2, {30'h0, divided_phase_a_out, divided_phase_b_out});
    i_enc.send(3, 25, 1'b0);
    repeat (30) @(negedge clock);
    chk("edges down", 32'd6, 32'(n_edges));
    chk("phases down", 32'h0, {30'h0, divided_phase_a_out, divided_phase_b_out});
    chk("spaced overspeed", 32'h0, {31'h0, divided_output_overspeed_alarm});
    chk("speed ext", external_speed, speed_feedback);
    chk("source ext", 32'h1, {31'h0, speed_from_external});
    $display("t_pulses done");
  endtask : t_pulses
  task automatic t_resolution;
    restart(13'h1388, fcl_pkg::EXT_ENC_NOT_USED, fcl_pkg::SPD_SRC_EXT);
    i_enc.send(5, 25, 1'b1);
    repeat (30) @(negedge clock);
    chk("edges clamped", 32'd5, 32'(n_edges));
    chk("speed unused ext", motor_speed, speed_feedback);
    chk("source unused ext", 32'h0, {31'h0, speed_from_external});
    restart(fcl_pkg::RES_DEFAULT, 2'h1, fcl_pkg::SPD_SRC_MOTOR);
    i_enc.send(204, 0, 1'b1);
    repeat (30) @(negedge clock);
    chk("edges 204 counts", 32'd0, 32'(n_edges));
    i_enc.send(1, 0, 1'b1);
    repeat (30) @(negedge clock);
    chk("edges 205 counts", 32'd1, 32'(n_edges));
    chk("speed motor", motor_speed, speed_feedback);
    $display("t_resolution done");
  endtask : t_resolution
  task automatic t_overspeed;
    restart(fcl_pkg::RES_MAX, 2'h1, fcl_pkg::SPD_SRC_MOTOR);
    i_enc.send(4, 0, 1'b1);
    repeat (100) @(negedge clock);
    chk("overspeed", 32'h1, {31'h0, divided_output_overspeed_alarm});
    chk("edges burst", 32'd4, 32'(n_edges));
    $display("t_overspeed done");
  endtask : t_overspeed
  task automatic rotate(input logic [6:0] mult);
    per_rotation_deviation_multiplier = mult;
    rotation_start = 1'b1;
    @(negedge clock);
    rotation_start = 1'b0;
    repeat (4) @(negedge clock);
  endtask : rotate
  task automatic t_deviation;
    motor_position = 32'h0000_03E8;
    repeat (4) @(negedge clock);
    chk("deviation", 32'h0000_03E8, motor_load_deviation);
    chk("monitor one", 32'h0000_03E8, analog_monitor_one);
    chk("monitor two", 32'h0000_0000, analog_monitor_two);
    rotate(fcl_pkg::MULT_DEFAULT);
    chk("carry 0.8", 32'h0000_0320, motor_load_deviation);
    rotate(fcl_pkg::MULT_DEFAULT);
    chk("carry 0.64", 32'h0000_0280, motor_load_deviation);
    chk("corrected load", 32'h0000_0168, corrected_load_position);
    rotate(7'h00);
    chk("carry none", 32'h0000_03E8, motor_load_deviation);
    chk("corrected none", 32'h0000_0000, corrected_load_position);
    chk("alarm off", 32'h0, {31'h0, motor_load_error_overflow_alarm});
    motor_load_error_threshold = fcl_pkg::ERR_THRESH_DEFAULT;
    repeat (4) @(negedge clock);
    chk("alarm at level", 32'h0, {31'h0, motor_load_error_overflow_alarm});
    motor_position = 32'h0000_03E9;
    repeat (4) @(negedge clock);
    chk("alarm over level", 32'h1, {31'h0, motor_load_error_overflow_alarm});
    analog_monitor_two_select = fcl_pkg::MON_SEL_DEVIATION;
    repeat (2) @(negedge clock);
    chk("monitor two sel", 32'h0000_03E9, analog_monitor_two);
    $display("t_deviation done");
  endtask : t_deviation
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    {rotation_direction_select, rotation_start, load_position} = '0;
    {divided_output_resolution, external_encoder_usage, speed_feedback_source_select} = '0;
    {motor_position, motor_load_error_threshold, per_rotation_deviation_multiplier} = '0;
    analog_monitor_one_select = fcl_pkg::MON_SEL_DEVIATION;
    analog_monitor_two_select = 8'h00;
    motor_speed    = 32'h0000_1111;
    external_speed = 32'h0000_2222;
    t_pulses();
    t_resolution();
    t_overspeed();
    t_deviation();
    print_verdict();
  end
endmodule : test_fully_closed_loop_feedback
